// ==== hdl/lpw_consts.vh ====
// How it works
// - fixed priority picks vector, reset highest
// - timer one vectors at FFF2 FFF4 FFF6
// - timer two vectors at FFEC FFEE FFF0
// - serial FFE2 FFE4 FFE6, keyboard FFE0
// - spi FFE8 FFEA, pll FFF8, irq FFFA
// - wait stops cpu clock, bus runs
// - stop stops cpu, bus unless osc-run
// - entry clears mask; reset exit sets it
// - stop aborts adc; resumes after interrupt
// - adc runs in wait, wakes cpu
// - break wakes stop, sets halt flag
// - break active in wait, flag set
// - stop without osc-run: generator outputs low
// - osc-run: pll off, oscillator runs
// - clock generator stays active in wait
// - stop gates watchdog clock, clears prescaler
// - stop honoured only when halt enable set
// - watchdog keeps counting in wait
// - irq wakes when its mask clear
// - keyboard wakes when its mask clear
// - cpu clock held until recovery done
// - recovery 4096 or 32 oscillator cycles
// - timebase rollover wakes stop via FFDC when osc-run
`ifndef LPW_CONSTS_VH
`define LPW_CONSTS_VH
// ****************************************
// vector addresses (high byte address)
// ****************************************
`define LPW_VEC_TBM   16'hFFDC
`define LPW_VEC_ADC   16'hFFDE
`define LPW_VEC_KBD   16'hFFE0
`define LPW_VEC_SCTX  16'hFFE2
`define LPW_VEC_SCRX  16'hFFE4
`define LPW_VEC_SCER  16'hFFE6
`define LPW_VEC_SPTX  16'hFFE8
`define LPW_VEC_SPRX  16'hFFEA
`define LPW_VEC_T2OV  16'hFFEC
`define LPW_VEC_T2C1  16'hFFEE
`define LPW_VEC_T2C0  16'hFFF0
`define LPW_VEC_T1OV  16'hFFF2
`define LPW_VEC_T1C1  16'hFFF4
`define LPW_VEC_T1C0  16'hFFF6
`define LPW_VEC_PLL   16'hFFF8
`define LPW_VEC_IRQ   16'hFFFA
`define LPW_VEC_SWI   16'hFFFC
`define LPW_VEC_RST   16'hFFFE
// ****************************************
// recovery counts in oscillator cycles
// ****************************************
`define LPW_REC_LONG  12'hFFF
`define LPW_REC_SHORT 12'h01F
// ****************************************
// number of sources in request vector
// ****************************************
`define LPW_NSRC      17
`endif

// ==== hdl/lpw_wake_ctrl.v ====
`timescale 1ns/10ps
`include "lpw_consts.vh"
// source vector order, bit 0 lowest priority:
// 0 tbm 1 adc 2 kbd 3 sci-tx 4 sci-rx 5 sci-err 6 spi-tx 7 spi-rx
// 8 t2ov 9 t2c1 10 t2c0 11 t1ov 12 t1c1 13 t1c0 14 pll 15 irq 16 swi
module lpw_wake_ctrl (
    input  wire        sys_clk,             // system clock 250 MHz
    input  wire        rst,                 // async reset, active high
    input  wire        resetReq,            // pin/watchdog/monitor reset
    input  wire [16:0] intReq,              // pending interrupt sources
    input  wire        breakReq,            // break interrupt request
    input  wire        waitExec,            // cpu executes wait, pulse
    input  wire        stopExec,            // cpu executes stop, pulse
    input  wire        haltInstrEnable,     // config: stop allowed
    input  wire        oscillatorKeepRunning, // config: osc runs in stop
    input  wire        shortRecoverySelect, // config: 32-cycle recovery
    input  wire        irqRequestMask,      // irq mask, 1 blocks wake
    input  wire        keyboardRequestMask, // keyboard mask, 1 blocks
    input  wire        watchdogClear,       // software watchdog service
    input  wire        breakFlagClear,      // software clears break flag
    input  wire        intAck,              // cpu took presented vector
    output reg         cpuClkEn,            // cpu clock gate
    output reg         busClkEn,            // bus clock gate
    output reg         oscEnable,           // crystal oscillator enable
    output reg         pllEnable,           // pll allowed to run
    output reg         oscClkOutEn,         // oscillator clock out gate
    output reg         genClkOutEn,         // generator clock out gate
    output reg         genIntEn,            // generator interrupt gate
    output reg         watchdogClkEn,       // watchdog clock gate
    output reg         watchdogPrescClr,    // clear watchdog prescaler
    output reg         adcAbort,            // abort/hold the adc
    output reg         irqMaskSet,          // set cpu interrupt mask
    output reg         irqMaskClr,          // clear cpu interrupt mask
    output reg         haltWaitBreakFlag,   // break during wait/stop
    output reg         vecValid,            // vector presented
    output reg  [15:0] vecAddr,             // high-byte vector address
    output reg         inWait,              // wait mode status
    output reg         inStop               // stop mode status
);
    // ****************************************
    // states
    // ****************************************
    localparam [1:0] ST_RUN  = 2'b00;       // normal running
    localparam [1:0] ST_WAIT = 2'b01;       // wait mode
    localparam [1:0] ST_STOP = 2'b10;       // stop mode
    localparam [1:0] ST_REC  = 2'b11;       // stop recovery
    parameter [11:0] REC_LONG  = `LPW_REC_LONG;  // 4096 cycles less one
    parameter [11:0] REC_SHORT = `LPW_REC_SHORT; // 32 cycles less one

    reg  [1:0]  state_reg;                  // mode state
    reg  [1:0]  state_next;                 // next mode state
    reg  [11:0] recCnt_reg;                 // 12-bit recovery counter
    reg  [11:0] recCnt_next;                // its next value
    reg  [16:0] intSync1_reg;               // sync stage one
    reg  [16:0] intSync2_reg;               // sync stage two
    reg  [2:0]  miscSync1_reg;              // reset, break, tb sync 1
    reg  [2:0]  miscSync2_reg;              // reset, break, tb sync 2
    reg         tbmWake_reg;                // rollover seen in stop
    wire [16:0] intS;                       // synchronised requests
    wire        rstS;                       // synchronised reset req
    wire        brkS;                       // synchronised break req
    wire [16:0] intGated;                   // requests after masks
    wire        stopWake;                   // wake sources for stop
    wire        waitWake;                   // wake sources for wait
    wire        anyWake;                    // combined wake

    // ****************************************
    // priority encoder
    // ****************************************
    // highest set bit wins, swi at top; reset handled separately
    function [15:0] pickVec;
        input [16:0] req;
        begin
            pickVec = `LPW_VEC_TBM;
            if (req[1])  pickVec = `LPW_VEC_ADC;
            if (req[2])  pickVec = `LPW_VEC_KBD;
            if (req[3])  pickVec = `LPW_VEC_SCTX;
            if (req[4])  pickVec = `LPW_VEC_SCRX;
            if (req[5])  pickVec = `LPW_VEC_SCER;
            if (req[6])  pickVec = `LPW_VEC_SPTX;
            if (req[7])  pickVec = `LPW_VEC_SPRX;
            if (req[8])  pickVec = `LPW_VEC_T2OV;
            if (req[9])  pickVec = `LPW_VEC_T2C1;
            if (req[10]) pickVec = `LPW_VEC_T2C0;
            if (req[11]) pickVec = `LPW_VEC_T1OV;
            if (req[12]) pickVec = `LPW_VEC_T1C1;
            if (req[13]) pickVec = `LPW_VEC_T1C0;
            if (req[14]) pickVec = `LPW_VEC_PLL;
            if (req[15]) pickVec = `LPW_VEC_IRQ;
            if (req[16]) pickVec = `LPW_VEC_SWI;
        end
    endfunction

    // ****************************************
    // input synchronisers
    // ****************************************
    // requests come from peripherals that may be clock gated
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            intSync1_reg  <= 17'h00000;
            intSync2_reg  <= 17'h00000;
            miscSync1_reg <= 3'h0;
            miscSync2_reg <= 3'h0;
        end else begin
            intSync1_reg  <= intReq;
            intSync2_reg  <= intSync1_reg;
            miscSync1_reg <= {resetReq, breakReq, intReq[0]};
            miscSync2_reg <= miscSync1_reg;
        end
    end
    assign intS = intSync2_reg;
    assign rstS = miscSync2_reg[2];
    assign brkS = miscSync2_reg[1];

    // masks: irq and keyboard only wake while their mask is clear
    assign intGated = intS & ~{1'b0, irqRequestMask, 12'h000,
                               keyboardRequestMask, 2'b00};
    // stop: only irq, keyboard, break, reset, tbm when osc runs
    assign stopWake = rstS | brkS |
                      (intGated[15] | intGated[2]) |
                      (tbmWake_reg & oscillatorKeepRunning);
    // wait: any enabled request incl. adc completion
    assign waitWake = rstS | brkS | (|intGated);
    assign anyWake  = (state_reg == ST_STOP) ? stopWake : waitWake;

    // ****************************************
    // mode state machine
    // ****************************************
    always @* begin
        state_next  = state_reg;
        recCnt_next = recCnt_reg;
        case (state_reg)
            ST_RUN: begin
                if (stopExec && haltInstrEnable) begin
                    state_next = ST_STOP;
                end else if (waitExec) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (anyWake) state_next = ST_RUN;
            end
            ST_STOP: begin
                if (anyWake) begin
                    state_next  = ST_REC;
                    recCnt_next = shortRecoverySelect ?
                                  REC_SHORT : REC_LONG;
                end
            end
            ST_REC: begin
                if (recCnt_reg == 12'h000) state_next = ST_RUN;
                else recCnt_next = recCnt_reg - 12'h001;
            end
            default: state_next = ST_RUN;
        endcase
    end

    // ****************************************
    // registers and outputs
    // ****************************************
    // every output comes from a flop; gates follow state_next
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg         <= ST_RUN;
            recCnt_reg        <= 12'h000;
            tbmWake_reg       <= 1'b0;
            cpuClkEn          <= 1'b1;
            busClkEn          <= 1'b1;
            oscEnable         <= 1'b1;
            pllEnable         <= 1'b1;
            oscClkOutEn       <= 1'b1;
            genClkOutEn       <= 1'b1;
            genIntEn          <= 1'b1;
            watchdogClkEn     <= 1'b1;
            watchdogPrescClr  <= 1'b0;
            adcAbort          <= 1'b0;
            irqMaskSet        <= 1'b0;
            irqMaskClr        <= 1'b0;
            haltWaitBreakFlag <= 1'b0;
            vecValid          <= 1'b0;
            vecAddr           <= `LPW_VEC_RST;
            inWait            <= 1'b0;
            inStop            <= 1'b0;
        end else begin
            state_reg  <= state_next;
            recCnt_reg <= recCnt_next;
            // rollover latched only while stopped; wakes only with osc running
            if (state_reg == ST_STOP)
                tbmWake_reg <= tbmWake_reg | miscSync2_reg[0];
            else
                tbmWake_reg <= 1'b0;
            // cpu clock off in wait, stop and recovery
            cpuClkEn <= (state_next == ST_RUN);
            // bus runs in wait; in stop only with osc kept running
            busClkEn <= (state_next == ST_RUN) ||
                        (state_next == ST_WAIT) ||
                        oscillatorKeepRunning;
            // clock generator: fully active in wait, gated in stop
            oscEnable   <= (state_next != ST_STOP) ||
                           oscillatorKeepRunning;
            pllEnable   <= (state_next != ST_STOP);
            oscClkOutEn <= (state_next != ST_STOP) ||
                           oscillatorKeepRunning;
            genClkOutEn <= (state_next != ST_STOP);
            genIntEn    <= (state_next != ST_STOP);
            // watchdog counts in wait, loses clock in stop
            watchdogClkEn    <= (state_next != ST_STOP) &&
                                (state_next != ST_REC);
            watchdogPrescClr <= (state_next == ST_STOP) |
                                watchdogClear;
            // adc held aborted through stop and recovery
            adcAbort <= (state_next == ST_STOP) ||
                        (state_next == ST_REC);
            // mask cleared on entry, set on reset exit
            irqMaskClr <= (state_reg == ST_RUN) &&
                          (state_next != ST_RUN);
            irqMaskSet <= (state_reg != ST_RUN) && rstS &&
                          (state_next != state_reg);
            // break in wait/stop sets flag; set beats clear
            if (brkS && (state_reg == ST_WAIT ||
                         state_reg == ST_STOP))
                haltWaitBreakFlag <= 1'b1;
            else if (breakFlagClear)
                haltWaitBreakFlag <= 1'b0;
            // vector presented once clocks run again
            if (state_next == ST_RUN && state_reg != ST_RUN) begin
                vecValid <= 1'b1;
                // break shares the software-interrupt vector pair
                vecAddr  <= rstS ? `LPW_VEC_RST :
                            brkS ? `LPW_VEC_SWI :
                            pickVec(intGated);
            end else if (intAck) begin
                vecValid <= 1'b0;
            end
            inWait <= (state_next == ST_WAIT);
            inStop <= (state_next == ST_STOP) ||
                      (state_next == ST_REC);
        end
    end
endmodule // lpw_wake_ctrl

// ==== dv/lpw_wake_ctrl_asserts.sv ====
`timescale 1ns/10ps
// ****
// port checker for the low-power wake controller
// ****
module lpw_wake_ctrl_asserts (
    input wire        sys_clk, rst,          // clock and async reset
    input wire        waitExec, stopExec,    // instruction pulses
    input wire        haltInstrEnable,       // stop allowed
    input wire        oscillatorKeepRunning, // osc runs in stop
    input wire        breakReq, intAck,      // break and vector taken
    input wire        cpuClkEn, busClkEn,    // clock gates
    input wire        oscEnable, pllEnable,  // oscillator and pll
    input wire        oscClkOutEn,           // oscillator clock gate
    input wire        genClkOutEn, genIntEn, // generator outputs
    input wire        watchdogClkEn,         // watchdog clock gate
    input wire        watchdogPrescClr,      // watchdog prescaler clear
    input wire        adcAbort, irqMaskClr,  // adc hold, mask clear
    input wire        haltWaitBreakFlag,     // break status
    input wire        vecValid,              // vector presented
    input wire [15:0] vecAddr,               // vector address
    input wire        inWait, inStop         // mode status
);
    wire run = !inWait && !inStop; // only here are instructions taken
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_WAIT_GATES: assert property (
        inWait |-> busClkEn && !cpuClkEn && !adcAbort && genClkOutEn
        && pllEnable && oscEnable && watchdogClkEn)
        else $error("wait gates wrong");
    AST_STOP_CPU: assert property (
        inStop |-> !cpuClkEn) else $error("cpu clock on in stop");
    AST_STOP_OFF: assert property (
        $rose(inStop) && !oscillatorKeepRunning |-> !busClkEn && !oscEnable
        && !oscClkOutEn && !genClkOutEn && !genIntEn)
        else $error("stop left a clock running");
    AST_STOP_OSC: assert property (
        $rose(inStop) && oscillatorKeepRunning |-> oscEnable && !pllEnable)
        else $error("osc-run stop gates wrong");
    AST_STOP_SIDE: assert property (
        $rose(inStop) |-> adcAbort && !watchdogClkEn && watchdogPrescClr)
        else $error("stop side effects missing");
    AST_HALT_GATE: assert property (
        run && stopExec && !waitExec && !haltInstrEnable |=> !inStop)
        else $error("disabled stop was taken");
    AST_WAIT_ENTER: assert property (
        run && waitExec && !stopExec |=> inWait && irqMaskClr)
        else $error("wait entry wrong");
    AST_STOP_ENTER: assert property (
        run && stopExec && haltInstrEnable |=> inStop && irqMaskClr)
        else $error("stop entry wrong");
    AST_VEC_HOLD: assert property (
        vecValid && !intAck |=> vecValid && $stable(vecAddr))
        else $error("vector dropped before ack");
    AST_BRK_FLAG: assert property (
        breakReq && (inStop || inWait) |-> ##[1:5] haltWaitBreakFlag)
        else $error("break flag not set");
    cover property ($rose(inWait));
    cover property ($rose(inStop));
    cover property (vecValid && intAck);
endmodule // lpw_wake_ctrl_asserts
bind lpw_wake_ctrl lpw_wake_ctrl_asserts i_chk (.*);

// ==== dv/lpw_cpu_model.sv ====
`timescale 1ns/10ps
// ****
// cpu core model: takes each presented vector after a delay
// ****
module lpw_cpu_model #(
    parameter ACK_DELAY = 5 // long enough for synced requests to fall
) (
    input  wire sys_clk,  // clock
    input  wire rst,      // async reset
    input  wire vecValid, // vector presented
    output reg  intAck    // one-cycle take pulse
);
    reg [3:0] waitCnt_reg; // cycles the vector has stood
    // ack changes just after the edge, like a real core fetching
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            waitCnt_reg <= 4'h0;
            intAck      <= 1'b0;
        end else begin
            waitCnt_reg <= (vecValid && !intAck) ? waitCnt_reg + 4'h1 : 4'h0;
            intAck <= #1 vecValid && !intAck &&
                      (waitCnt_reg == ACK_DELAY - 1);
        end
    end
endmodule // lpw_cpu_model

// ==== dv/lpw_wake_ctrl_bench.sv ====
`timescale 1ns/10ps
// ****
// bench: mode entries and wakes with vector and latency checks
// ****
module lpw_wake_ctrl_bench;
    localparam [11:0] REC = 12'h00F; // shortened long recovery
    reg        sys_clk, rst, resetReq, breakReq, waitExec, stopExec;
    reg        haltInstrEnable, oscillatorKeepRunning, shortRecoverySelect;
    reg        irqRequestMask, keyboardRequestMask, watchdogClear;
    reg        breakFlagClear, maskSeen;  // maskSeen: sticky set pulse
    reg [16:0] intReq;                    // source requests
    wire       cpuClkEn, busClkEn, oscEnable, pllEnable, oscClkOutEn;
    wire       genClkOutEn, genIntEn, watchdogClkEn, watchdogPrescClr;
    wire       adcAbort, irqMaskSet, irqMaskClr, haltWaitBreakFlag;
    wire       vecValid, inWait, inStop, intAck;
    wire [15:0] vecAddr;
    integer    fail_count, comparisons, cyc, i;
    lpw_wake_ctrl #(.REC_LONG(REC)) i_dut (.*);
    lpw_cpu_model i_cpu (.*);
    always #2 sys_clk = ~sys_clk;
    // mask set is a one-cycle pulse, so it is caught at every edge
    always @(posedge sys_clk) begin
        if (irqMaskSet === 1'b1) maskSeen = 1'b1;
        cyc = cyc + 1;
        if (cyc == 5000) begin // a hang ends the run
            fail_count = fail_count + 1;
            $display("[ERR] run expected end seen hang");
            print_verdict;
        end
    end
    task print_verdict;
        begin
            $display("mismatches %0d comparisons %0d", fail_count, comparisons);
            if (fail_count == 0 && comparisons > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [8*9-1:0] nm, input [15:0] exp, input [15:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task chkLat(input integer n, input integer lo, input integer hi);
        begin
            comparisons = comparisons + 1;
            if (n < lo || n > hi) begin
                fail_count = fail_count + 1;
                $display("[ERR] latency expected %0d..%0d seen %0d", lo, hi, n);
            end
        end
    endtask
    // inputs move 1 ns after the rising edge
    task tick(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
            #1;
        end
    endtask
    task enter(input st);
        begin
            if (st) stopExec = 1'b1;
            else waitExec = 1'b1;
            tick(1);
            stopExec = 1'b0;
            waitExec = 1'b0;
            tick(3);
        end
    endtask
    // raise wake causes, time the cpu clock, check the vector (0 skips)
    task wake(input [16:0] rq, input break_unit, input rr, input [15:0] exp,
              input integer lo, input integer hi);
        integer n;
        begin
            intReq = rq;
            breakReq = break_unit;
            resetReq = rr;
            n = 0;
            while (cpuClkEn !== 1'b1 && n < 500) begin
                tick(1);
                n = n + 1;
            end
            chkLat(n, lo, hi);
            n = 0;
            while (vecValid !== 1'b1 && n < 20) begin
                tick(1);
                n = n + 1;
            end
            if (exp != 16'h0000) chk("vector", exp, vecAddr);
            intReq = 17'h00000;
            breakReq = 1'b0;
            resetReq = 1'b0;
            tick(12);
        end
    endtask
    task clrFlag;
        begin
            chk("brkFlag", 16'h0001, haltWaitBreakFlag);
            breakFlagClear = 1'b1;
            tick(1);
            breakFlagClear = 1'b0;
            tick(2);
            chk("brkFlag", 16'h0000, haltWaitBreakFlag);
        end
    endtask
    initial begin
        {sys_clk, resetReq, breakReq, waitExec, stopExec} = 5'h00;
        {oscillatorKeepRunning, shortRecoverySelect, watchdogClear} = 3'h0;
        {irqRequestMask, keyboardRequestMask, breakFlagClear} = 3'h0;
        {haltInstrEnable, rst, maskSeen, intReq} = {3'h6, 17'h00000};
        {fail_count, comparisons, cyc} = 96'h0;
        tick(8);
        rst = 1'b0;
        tick(2);
        // every source with all lower ones pending: highest wins
        for (i = 0; i < 17; i = i + 1) begin
            enter(1'b0);
            wake(17'h1FFFF >> (16 - i), 1'b0, 1'b0,
                 16'hFFDC + {i[14:0], 1'b0}, 1, 6);
        end
        haltInstrEnable = 1'b0; // stop refused while disabled
        enter(1'b1);
        chk("inStop", 16'h0000, inStop);
        haltInstrEnable = 1'b1;
        enter(1'b1);
        wake(17'h08000, 1'b0, 1'b0, 16'hFFFA, REC + 1, REC + 8);
        {shortRecoverySelect, oscillatorKeepRunning} = 2'h3;
        enter(1'b1);
        wake(17'h00004, 1'b0, 1'b0, 16'hFFE0, 32, 39);
        enter(1'b1);
        wake(17'h00001, 1'b0, 1'b0, 16'hFFDC, 32, 39);
        {shortRecoverySelect, oscillatorKeepRunning} = 2'h0;
        irqRequestMask = 1'b1; // masked irq must leave stop alone
        enter(1'b1);
        intReq = 17'h08000;
        tick(40);
        chk("cpuClkEn", 16'h0000, cpuClkEn);
        wake(17'h08000, 1'b1, 1'b0, 16'hFFFC, REC + 1, REC + 8);
        clrFlag;
        irqRequestMask = 1'b0;
        enter(1'b0);
        wake(17'h00000, 1'b1, 1'b0, 16'hFFFC, 1, 6);
        clrFlag;
        chk("maskSet", 16'h0000, maskSeen);
        maskSeen = 1'b0; // reset exit sets the cpu mask
        enter(1'b0);
        wake(17'h00000, 1'b0, 1'b1, 16'hFFFE, 1, 6);
        chk("maskSet", 16'h0001, maskSeen);
        print_verdict;
    end
endmodule // lpw_wake_ctrl_bench
